// ### rtl/cbr_cfg.svh
// Timing, field and size constants for the core bank request and cycle logic
`ifndef CBR_CFG_SVH
`define CBR_CFG_SVH

// Clock period and least-time conversion from ns to whole cycles
`define CBR_CLK_PS 8000
`define CBR_CYC(ns) ((((ns) * 1000) + `CBR_CLK_PS - 1) / `CBR_CLK_PS)

// Organisation and field layout of the request select
`define CBR_NBANK 32
`define CBR_NCHAS 8
`define CBR_BPC 4
`define CBR_SEL_W 5
`define CBR_BANK_LSB 0
`define CBR_BANK_MSB 1
`define CBR_CHAS_LSB 2
`define CBR_CHAS_MSB 4
`define CBR_WORD_W 60
`define CBR_ADDR_W 12
`define CBR_CTR_W 8
`define CBR_RETAIN_W 10

// Sequencer chain shape
`define CBR_NSTG 13
`define CBR_STG_MID 6
`define CBR_STEP_NS 50
`define CBR_STG_NS 400

// Link timing, relative to the go pulse except the tag, which counts from the address
`define CBR_ADDR_NS 50
`define CBR_TAG_NS 150
`define CBR_WDATA_NS 400
`define CBR_ACC_NS 200
`define CBR_RETRY_NS 300
`define CBR_RETAIN_NS 2700
`define CBR_ACC_LEN `CBR_CYC(`CBR_ACC_NS)

// Storage cycle timing, relative to the start of read drive
`define CBR_CYCLE_NS 1000
`define CBR_SENSE_NS 200
`define CBR_SENSE_LEN_NS 100
`define CBR_INH_NS 475
`define CBR_WRITE_NS 500
`define CBR_ENDINH_NS 900

`endif

// ### rtl/cbr_pkg.sv
// Types shared by the memory end and the request queue end
`include "cbr_cfg.svh"
package cbr_pkg;

  typedef logic [`CBR_CTR_W-1:0] cbr_ctr_type;
  typedef logic [`CBR_WORD_W-1:0] cbr_word_type;
  typedef logic [`CBR_ADDR_W-1:0] cbr_addr_type;
  typedef logic [`CBR_SEL_W-1:0] cbr_sel_type;
  typedef logic [`CBR_RETAIN_W-1:0] cbr_held_type;

  typedef enum logic [0:0] {CBR_Q_IDLE, CBR_Q_RUN} cbr_q_st_type;

  typedef struct packed {
    logic [`CBR_NBANK-1:0] run;
    logic [`CBR_NBANK-1:0][`CBR_CTR_W-1:0] ctr;
    logic [`CBR_NBANK-1:0][`CBR_NSTG-1:0] stg;
    logic [`CBR_NBANK-1:0][`CBR_ADDR_W-1:0] saddr;
    logic [`CBR_NBANK-1:0] wpend;
    logic [`CBR_NBANK-1:0] sense;
    logic [`CBR_NBANK-1:0] inh;
    logic [`CBR_NBANK-1:0][`CBR_WORD_W-1:0] xbuf;
    logic [`CBR_NBANK-1:0][`CBR_WORD_W-1:0] restore;
    logic [`CBR_ACC_LEN-1:0] acc_pipe;
    logic [`CBR_WORD_W-1:0] rd_word;
    logic rd_valid;
  } cbr_mem_state_type;

  typedef struct packed {
    cbr_q_st_type st;
    logic [`CBR_CTR_W-1:0] ctr;
    logic [`CBR_RETAIN_W-1:0] held;
    logic acc;
    logic wr;
    logic [`CBR_SEL_W-1:0] sel;
    logic [`CBR_ADDR_W-1:0] addr;
    logic [`CBR_WORD_W-1:0] wdata;
    logic go;
    logic addr_valid;
    logic write_tag;
    logic wdata_valid;
    logic done;
    logic overrun;
  } cbr_q_state_type;

endpackage

// ### rtl/cbr_link_if.sv
// Link between the request queue and the central memory banks
`timescale 1ns/1ps
`include "cbr_cfg.svh"
interface cbr_link_if;
  logic go;
  logic [`CBR_SEL_W-1:0] sel;
  logic addr_valid;
  logic [`CBR_ADDR_W-1:0] word_addr;
  logic write_tag;
  logic wdata_valid;
  logic [`CBR_WORD_W-1:0] wdata;
  logic accept;

  modport memory_end (
    input go, sel, addr_valid, word_addr, write_tag, wdata_valid, wdata,
    output accept
  );

  modport queue_end (
    output go, sel, addr_valid, word_addr, write_tag, wdata_valid, wdata,
    input accept
  );
endinterface

// ### rtl/cbr_chassis_sel.sv
// Chassis compare and bank go gating for one memory chassis
`timescale 1ns/1ps
`include "cbr_cfg.svh"
module cbr_chassis_sel #(
  parameter logic [`CBR_CHAS_MSB-`CBR_CHAS_LSB:0] CHASSIS = 3'h0
) (
  // Broadcast request
  input wire logic go,
  input wire logic [`CBR_SEL_W-1:0] sel,
  // Bank state and result
  input wire logic [`CBR_BPC-1:0] bank_free,
  output logic [`CBR_BPC-1:0] bank_go
);

  logic [`CBR_CHAS_MSB-`CBR_CHAS_LSB:0] preset;
  logic [`CBR_CHAS_MSB-`CBR_CHAS_LSB:0] cmp;
  logic chas_go;

  function automatic logic bank_hit(input logic [`CBR_BANK_MSB:0] f, input int idx);
    bank_hit = (f == idx[`CBR_BANK_MSB:0]);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Compare flops preset to own complement, address bits flip them true
  assign preset = ~CHASSIS; // [RULE_03]
  assign cmp = preset ^ sel[`CBR_CHAS_MSB:`CBR_CHAS_LSB]; // [RULE_02]
  assign chas_go = go && (&cmp); // [RULE_03]

  //////////////////////////////////////////////////////////////////////////
  // Bank select, gated by bank free
  for (genvar i = 0; i < `CBR_BPC; i++) begin : g_bank
    assign bank_go[i] = chas_go && bank_hit(sel[`CBR_BANK_MSB:`CBR_BANK_LSB], i)
                        && bank_free[i]; // [RULE_02] [RULE_04]
  end

endmodule // cbr_chassis_sel

// ### rtl/cbr_memory_end.sv
// Central memory end: bank decode, accept return and per-bank storage sequencers
//
// Contract
// [RULE_01] Go with address broadcast; free bank accepts
// [RULE_02] Chassis from bits 2-4, bank from 0-1
// [RULE_03] Compare flops preset to complement, AND with go
// [RULE_04] No accept while bank still cycling
// [RULE_05] Queue retries rejected address every 300 ns
// [RULE_06] Accept returns 200 ns after go
// [RULE_07] Accepts ORed; one every 100 ns possible
// [RULE_08] Accepted request starts 1000 ns storage cycle
// [RULE_09] Address at 50 ns, latched by free banks
// [RULE_10] Storage address held stable whole cycle; code loads it 7 cycles after read drive starts
// [RULE_11] Shift chain, 50 ns steps, 400 ns stages
// [RULE_12] Bank free drops when read flop sets
// [RULE_13] Read drive 400 ns to all modules
// [RULE_14] Sense 100 ns at 200 ns, merges buffer
// [RULE_15] Inhibit drive starts at 475 ns
// [RULE_16] Restore holds complement; zero bits inhibit
// [RULE_17] End inhibit at 900 ns clears restore
// [RULE_18] Write drive at 500 ns, same cores
// [RULE_19] Write tag 150 ns after address; buffer replaced
// [RULE_20] Only bank at matching point takes write
// [RULE_21] Queue never holds read and write together
// [RULE_22] Free only when read, middle, write clear
`timescale 1ns/1ps
`include "cbr_cfg.svh"
module cbr_memory_end (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link to request queue
  cbr_link_if.memory_end link,
  // Sense amplifier words, one per bank
  input wire logic [`CBR_NBANK-1:0][`CBR_WORD_W-1:0] sense_word,
  // Drive enables, inhibit bits, storage address and bank free, per bank
  output logic [`CBR_NBANK-1:0] read_drive,
  output logic [`CBR_NBANK-1:0] write_drive,
  output logic [`CBR_NBANK-1:0] inhibit_drive,
  output logic [`CBR_NBANK-1:0][`CBR_WORD_W-1:0] inhibit_bits,
  output logic [`CBR_NBANK-1:0][`CBR_ADDR_W-1:0] store_addr,
  output logic [`CBR_NBANK-1:0] bank_free,
  // Word toward the distributor
  output logic [`CBR_WORD_W-1:0] read_word,
  output logic read_valid
);

  cbr_pkg::cbr_mem_state_type s;
  cbr_pkg::cbr_mem_state_type n;
  logic [`CBR_NBANK-1:0] bank_go;

  // True while counter c lies in [start, start+len) ns, least-time rounding
  function automatic logic in_win(input cbr_pkg::cbr_ctr_type c, input int start_ns,
                                  input int len_ns);
    in_win = (c >= cbr_pkg::cbr_ctr_type'(`CBR_CYC(start_ns)))
             && (c < cbr_pkg::cbr_ctr_type'(`CBR_CYC(start_ns + len_ns)));
  endfunction

  // Counter value of a bank at a link time point measured from go
  function automatic cbr_pkg::cbr_ctr_type go_pt(input int ns);
    go_pt = cbr_pkg::cbr_ctr_type'(`CBR_CYC(ns) - 1);
  endfunction

  // Counter value at a cycle time measured from read start
  function automatic cbr_pkg::cbr_ctr_type rd_pt(input int ns);
    rd_pt = cbr_pkg::cbr_ctr_type'(`CBR_CYC(ns));
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Chassis decode and bank free
  for (genvar c = 0; c < `CBR_NCHAS; c++) begin : g_chas
    cbr_chassis_sel #(
      .CHASSIS(3'(c))
    ) u_sel (
      .go(link.go), // [RULE_01]
      .sel(link.sel),
      .bank_free(bank_free[c*`CBR_BPC +: `CBR_BPC]),
      .bank_go(bank_go[c*`CBR_BPC +: `CBR_BPC])
    );
  end

  for (genvar b = 0; b < `CBR_NBANK; b++) begin : g_free
    assign bank_free[b] = ~(s.stg[b][0] | s.stg[b][`CBR_STG_MID]
                            | s.stg[b][`CBR_NSTG-1]); // [RULE_22] [RULE_12]
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = s;
    // Any chassis accept enters the common return pipe
    n.acc_pipe = {s.acc_pipe[`CBR_ACC_LEN-2:0], |bank_go}; // [RULE_06] [RULE_07]
    n.rd_word = '0;
    n.rd_valid = 1'b0;
    for (int b = 0; b < `CBR_NBANK; b++) begin
      // Cycle counter of the bank
      if (bank_go[b]) begin
        n.run[b] = 1'b1; // [RULE_08]
        n.ctr[b] = '0;
      end else if (s.run[b]) begin
        n.ctr[b] = cbr_pkg::cbr_ctr_type'(s.ctr[b] + 1'b1);
        if (s.ctr[b] == rd_pt(`CBR_CYCLE_NS) - 1'b1) begin
          n.run[b] = 1'b0; // [RULE_08]
        end
      end
      // Chain stages, one every step, each held for a stage time
      for (int k = 0; k < `CBR_NSTG; k++) begin
        n.stg[b][k] = n.run[b] && in_win(n.ctr[b], k * `CBR_STEP_NS, `CBR_STG_NS); // [RULE_11]
      end
      n.sense[b] = n.run[b] && in_win(n.ctr[b], `CBR_SENSE_NS, `CBR_SENSE_LEN_NS); // [RULE_14]
      n.inh[b] = n.run[b]
                 && in_win(n.ctr[b], `CBR_INH_NS, `CBR_ENDINH_NS - `CBR_INH_NS); // [RULE_15]
      // Address latch: free banks, or the bank just started by this go
      if (link.addr_valid && (bank_free[b]
          || (s.run[b] && s.ctr[b] == go_pt(`CBR_ADDR_NS)))) begin
        n.saddr[b] = link.word_addr; // [RULE_09] [RULE_10]
      end
      // Write tag caught only at this bank's own time point
      if (bank_go[b]) begin
        n.wpend[b] = 1'b0;
      end else if (link.write_tag && s.run[b]
                   && s.ctr[b] == go_pt(`CBR_ADDR_NS) + rd_pt(`CBR_TAG_NS)) begin
        n.wpend[b] = 1'b1; // [RULE_19] [RULE_20]
      end
      // Exit/entry buffer
      if (bank_go[b]) begin
        n.xbuf[b] = '0;
      end else if (s.sense[b]) begin
        n.xbuf[b] = s.xbuf[b] | sense_word[b]; // [RULE_14]
      end else if (s.wpend[b] && s.run[b]
                   && s.ctr[b] == rd_pt(`CBR_SENSE_NS + `CBR_SENSE_LEN_NS)) begin
        n.xbuf[b] = '0; // [RULE_19]
      end else if (s.wpend[b] && link.wdata_valid && s.run[b]
                   && s.ctr[b] == go_pt(`CBR_WDATA_NS)) begin
        n.xbuf[b] = link.wdata; // [RULE_20]
      end
      // Restore register holds complement only while inhibit runs
      if (!n.inh[b]) begin
        n.restore[b] = '0; // [RULE_17]
      end else if (!s.inh[b]) begin
        n.restore[b] = ~s.xbuf[b]; // [RULE_16]
      end
      // Sensed word of a read goes to the distributor once sensing ends
      if (s.run[b] && !s.wpend[b]
          && s.ctr[b] == rd_pt(`CBR_SENSE_NS + `CBR_SENSE_LEN_NS)) begin
        n.rd_word = n.rd_word | s.xbuf[b]; // [RULE_14]
        n.rd_valid = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.accept = s.acc_pipe[`CBR_ACC_LEN-1]; // [RULE_06] [RULE_04]

  for (genvar b = 0; b < `CBR_NBANK; b++) begin : g_out
    assign read_drive[b] = s.stg[b][0]; // [RULE_13]
    assign write_drive[b] = s.stg[b][`CBR_WRITE_NS / `CBR_STEP_NS]; // [RULE_18]
  end

  assign inhibit_drive = s.inh; // [RULE_15] [RULE_17]
  assign inhibit_bits = s.restore; // [RULE_16]
  assign store_addr = s.saddr; // [RULE_10]
  assign read_word = s.rd_word;
  assign read_valid = s.rd_valid;

endmodule // cbr_memory_end

// ### rtl/cbr_queue_end.sv
// Request queue end: one retry register issuing go, address, tag and write word
`timescale 1ns/1ps
`include "cbr_cfg.svh"
module cbr_queue_end (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link to central memory
  cbr_link_if.queue_end link,
  // Request from the user
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [`CBR_SEL_W-1:0] req_sel,
  input wire logic [`CBR_ADDR_W-1:0] req_addr,
  input wire logic req_write,
  input wire logic [`CBR_WORD_W-1:0] req_wdata,
  // Status
  output logic done,
  output logic overrun
);

  cbr_pkg::cbr_q_state_type s;
  cbr_pkg::cbr_q_state_type n;

  function automatic cbr_pkg::cbr_ctr_type cyc(input int ns);
    cyc = cbr_pkg::cbr_ctr_type'(`CBR_CYC(ns));
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = s;
    n.done = 1'b0;
    case (s.st)
      cbr_pkg::CBR_Q_IDLE: begin
        // Only one request held, so never a read beside a write
        if (req_valid) begin
          n.st = cbr_pkg::CBR_Q_RUN; // [RULE_21]
          n.ctr = '0;
          n.held = '0;
          n.acc = 1'b0;
          n.overrun = 1'b0;
          n.sel = req_sel;
          n.addr = req_addr;
          n.wr = req_write;
          n.wdata = req_wdata;
        end
      end
      cbr_pkg::CBR_Q_RUN: begin
        n.ctr = cbr_pkg::cbr_ctr_type'(s.ctr + 1'b1);
        if (s.held != '1) begin
          n.held = cbr_pkg::cbr_held_type'(s.held + 1'b1);
        end
        if (s.held == cbr_pkg::cbr_held_type'(`CBR_CYC(`CBR_RETAIN_NS))) begin
          n.overrun = 1'b1; // [RULE_05]
        end
        if (link.accept && s.ctr == cyc(`CBR_ACC_NS)) begin
          n.acc = 1'b1; // [RULE_06]
        end
        if (s.acc && (!s.wr || s.ctr == cyc(`CBR_WDATA_NS))) begin
          n.st = cbr_pkg::CBR_Q_IDLE;
          n.done = 1'b1;
        end else if (!s.acc && s.ctr == cyc(`CBR_RETRY_NS) - 1'b1) begin
          n.ctr = '0; // [RULE_05]
        end
      end
      default: begin
        n.st = cbr_pkg::CBR_Q_IDLE;
      end
    endcase
    // Link strobes, registered from the next count
    n.go = (n.st == cbr_pkg::CBR_Q_RUN) && (n.ctr == '0); // [RULE_01]
    n.addr_valid = (n.st == cbr_pkg::CBR_Q_RUN) && (n.ctr == cyc(`CBR_ADDR_NS)); // [RULE_09]
    // Tag and word only follow an accepted go, so no bank sees a stray one
    n.write_tag = (n.st == cbr_pkg::CBR_Q_RUN) && n.wr && n.acc
                  && (n.ctr == cyc(`CBR_ADDR_NS) + cyc(`CBR_TAG_NS)); // [RULE_19]
    n.wdata_valid = (n.st == cbr_pkg::CBR_Q_RUN) && n.wr && n.acc
                    && (n.ctr == cyc(`CBR_WDATA_NS));
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign req_ready = (s.st == cbr_pkg::CBR_Q_IDLE);
  assign link.go = s.go;
  assign link.sel = s.sel;
  assign link.addr_valid = s.addr_valid;
  assign link.word_addr = s.addr;
  assign link.write_tag = s.write_tag;
  assign link.wdata_valid = s.wdata_valid;
  assign link.wdata = s.wdata;
  assign done = s.done;
  assign overrun = s.overrun;

endmodule // cbr_queue_end

// ### tb/cbr_link_assertions.sv
// Link timing checker between request queue and memory banks
`timescale 1ns/1ps
`include "cbr_cfg.svh"
module cbr_link_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link signals
  input wire logic go,
  input wire logic [`CBR_SEL_W-1:0] sel,
  input wire logic addr_valid,
  input wire logic write_tag,
  input wire logic wdata_valid,
  input wire logic accept
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last accept and its select
  logic [7:0] gap;
  logic [`CBR_SEL_W-1:0] lsel;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 8'hff;
      lsel <= '0;
    end else if (accept) begin
      gap <= 8'h00;
      lsel <= sel;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_refused;
    go ##25 !accept;
  endsequence

  a_go_pulse: assert property (go |=> !go)
    else $error("go longer than one cycle");
  a_sel_held: assert property (go |=> $stable(sel) [*8])
    else $error("select moved after go");
  a_accept_after_go: assert property (accept |-> $past(go, 25))
    else $error("accept not 25 cycles after go");
  a_accept_pulse: assert property (accept |=> !accept)
    else $error("accept longer than one cycle");
  a_retry_period: assert property (s_refused |-> ##13 go)
    else $error("refused request not reissued in time");
  a_addr_after_go: assert property (go |-> ##7 addr_valid)
    else $error("address not 7 cycles after go");
  a_tag_after_accept: assert property (write_tag |-> $past(accept))
    else $error("write tag without accept");
  a_word_after_accept: assert property (wdata_valid |-> $past(accept, 25))
    else $error("write word off its time point");
  a_busy_refused: assert property (accept && sel == lsel |-> gap >= 8'd124)
    else $error("busy bank accepted again");
endmodule // cbr_link_assertions

// ### tb/tb_core_bank_request_and_cycle_timing.sv
// Testbench joining the request queue end to the memory end
`timescale 1ns/1ps
`include "cbr_cfg.svh"
module tb_core_bank_request_and_cycle_timing;
  logic core_clk, rst_n, req_valid, req_write, req_ready, done, overrun, read_valid;
  cbr_pkg::cbr_sel_type req_sel;
  cbr_pkg::cbr_addr_type req_addr;
  cbr_pkg::cbr_word_type req_wdata, read_word, last_rv;
  cbr_pkg::cbr_word_type cap[32];
  cbr_pkg::cbr_addr_type csa[32];
  logic [`CBR_NBANK-1:0][`CBR_WORD_W-1:0] sense_word, inhibit_bits;
  logic [`CBR_NBANK-1:0][`CBR_ADDR_W-1:0] store_addr;
  logic [`CBR_NBANK-1:0] read_drive, write_drive, inhibit_drive, bank_free;
  logic [`CBR_NBANK-1:0] pr = '0, pw = '0, pi = '0, pf = '1;
  int fail_count = 0, checks_done = 0, cyc = 0, n_go = 0, n_rv = 0, lb = 0, t_go = 0, nr;
  int t_rd[32], t_rde[32], t_inh[32], t_wr[32], t_fr[32], t_bz[32], t_gb[32], t_ab[32];

  cbr_link_if link();
  cbr_memory_end i_cbr_memory_end (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .sense_word(sense_word), .read_drive(read_drive), .write_drive(write_drive),
    .inhibit_drive(inhibit_drive), .inhibit_bits(inhibit_bits), .store_addr(store_addr),
    .bank_free(bank_free), .read_word(read_word), .read_valid(read_valid));
  cbr_queue_end i_cbr_queue_end (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .req_valid(req_valid), .req_ready(req_ready), .req_sel(req_sel), .req_addr(req_addr),
    .req_write(req_write), .req_wdata(req_wdata), .done(done), .overrun(overrun));
  cbr_link_assertions i_cbr_link_assertions (.core_clk(core_clk), .rst_n(rst_n),
    .go(link.go), .sel(link.sel), .addr_valid(link.addr_valid), .write_tag(link.write_tag),
    .wdata_valid(link.wdata_valid), .accept(link.accept));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event times per bank, sampled mid-cycle
  always @(negedge core_clk) begin
    cyc++;
    if (link.go === 1'b1) begin
      t_go = cyc;
      n_go++;
    end
    if (link.accept === 1'b1) t_ab[lb] = cyc;
    if (read_valid === 1'b1) begin
      n_rv++;
      last_rv = read_word;
    end
    for (int b = 0; b < 32; b++) begin
      if (read_drive[b] && !pr[b]) begin
        t_rd[b] = cyc;
        t_gb[b] = t_go;
        lb = b;
      end
      if (!read_drive[b] && pr[b]) t_rde[b] = cyc;
      if (write_drive[b] && !pw[b]) begin
        t_wr[b] = cyc;
        csa[b] = store_addr[b];
      end
      if (inhibit_drive[b] && !pi[b]) t_inh[b] = cyc;
      if (inhibit_drive[b]) cap[b] = inhibit_bits[b];
      if (bank_free[b] && !pf[b]) t_fr[b] = cyc;
      if (!bank_free[b] && pf[b]) t_bz[b] = cyc;
    end
    pr = read_drive;
    pw = write_drive;
    pi = inhibit_drive;
    pf = bank_free;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input int got, input int exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s %0d, expected %0d", $time, m, got, exp);
    end
  endtask

  task automatic chk_w(input cbr_pkg::cbr_word_type got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s %h, expected %h", $time, m, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      $display("wrong value at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask

  function automatic cbr_pkg::cbr_word_type sw(input int b);
    return {12{b[4:0]}};
  endfunction

  // One request through the queue, waits for done
  task automatic req(input int s, input int a, input logic w, input cbr_pkg::cbr_word_type d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    bound(n, 400);
    req_sel = s[4:0];
    req_addr = a[11:0];
    req_write = w;
    req_wdata = d;
    req_valid = 1'b1;
    tick(1);
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 600) begin
      tick(1);
      n++;
    end
    bound(n, 600);
  endtask

  // Waits for the bank's cycle to end, then checks its timing and data
  task automatic bank(input int b, input int a, input cbr_pkg::cbr_word_type we, input logic rd);
    int n;
    n = 0;
    while (t_fr[b] <= t_rd[b] && n < 300) begin
      tick(1);
      n++;
    end
    bound(n, 300);
    chk(t_rd[b] - t_gb[b], 1, "drive start");
    chk(t_ab[b] - t_gb[b], `CBR_ACC_LEN, "accept");
    chk(t_bz[b], t_rd[b], "busy from");
    chk(t_rde[b] - t_rd[b], `CBR_CYC(`CBR_STG_NS), "read drive");
    chk(t_inh[b] - t_rd[b], `CBR_CYC(`CBR_INH_NS), "inhibit");
    chk(t_wr[b] - t_rd[b], `CBR_CYC(`CBR_WRITE_NS), "write drive");
    chk(t_fr[b] - t_rd[b], `CBR_CYC(`CBR_CYCLE_NS), "free after");
    chk_w(cbr_pkg::cbr_word_type'(csa[b]), cbr_pkg::cbr_word_type'(a[11:0]), "addr");
    chk_w(cap[b], ~we, "restore");
    if (rd) chk_w(last_rv, we, "read word");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_sel = '0;
    req_addr = '0;
    req_wdata = '0;
    for (int b = 0; b < 32; b++) sense_word[b] = sw(b);
    repeat (8) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    tick(1);
    req(5, 'h123, 1'b0, '0);
    bank(5, 'h123, sw(5), 1'b1);
    // Write replaces the sensed word and yields no read word
    nr = n_rv;
    req(30, 'hace, 1'b1, 60'h123456789abcdef);
    bank(30, 'hace, 60'h123456789abcdef, 1'b0);
    chk(n_rv, nr, "read words");
    // Second request to a busy bank retries until free
    req(5, 'h200, 1'b0, '0);
    nr = n_go;
    req(5, 'h201, 1'b0, '0);
    chk(int'(n_go - nr > 1), 1, "retries");
    chk_w(cbr_pkg::cbr_word_type'(overrun), '0, "overrun");
    bank(5, 'h201, sw(5), 1'b1);
    // Write word must reach only the bank at its write point
    req(8, 'h011, 1'b0, '0);
    req(9, 'h022, 1'b1, 60'hf0f0f0f0f0f0f0f);
    bank(8, 'h011, sw(8), 1'b1);
    bank(9, 'h022, 60'hf0f0f0f0f0f0f0f, 1'b0);
    // Every chassis and bank, each taken at first try
    for (int b = 0; b < 32; b++) begin
      nr = n_go;
      req(b, b * 3, 1'b0, '0);
      chk(lb, b, "bank started");
      chk(n_go - nr, 1, "gos");
    end
    bank(31, 93, sw(31), 1'b1);
    report_and_stop();
  end
endmodule // tb_core_bank_request_and_cycle_timing
